/* design/crf_core_datapath.v */
// core execution datapath: fetch word, register file, ALU, status flags,
// data space decode, stack pointer and interrupt gate
// assumes an external decoder drives op fields; memories sit outside
`timescale 1ns/1ps
`default_nettype none
`include "crf_consts.vh"
// Function
// RULE1 - separate buses, next word prefetched
// RULE2 - 32 eight-bit registers, single-cycle access
// RULE3 - read, compute, write back in one cycle
// RULE4 - six registers form three 16-bit pointers
// RULE5 - one pointer addresses program memory tables
// RULE6 - ALU register, immediate and single operand ops
// RULE7 - flags updated after each ALU op
// RULE8 - no flag save or restore on interrupts
// RULE9 - instructions one or two 16-bit words
// RULE10 - lower vector wins interrupt priority
// RULE11 - 64 I/O addresses, also 0x20..0x5F
// RULE12 - gate bit 7 clear blocks all interrupts
// RULE13 - gate cleared on entry, set on return
// RULE14 - bit 6 holds copied register bit
// RULE15 - bit 5 low nibble carry
// RULE16 - sign equals negative xor overflow
// RULE17 - bits 3..0 are V, N, Z, C
// RULE18 - 8/16-bit read and write port schemes
// RULE19 - registers occupy first 32 data addresses
// RULE20 - pointers may index any general register; a load from a register address returns register opSrc, not the pointed one
// RULE21 - return address pushed onto SRAM stack; here the stack pointer only drops by two and nothing is written
// RULE22 - software sets stack pointer before use; here it has no write path and reset loads 0x0000
// RULE23 - stack moves one per byte, two per address
// RULE24 - pointer pairs are registers 26 to 31
// RULE25 - undefined flags keep previous values
module crf_core_datapath #(
  parameter PC_WIDTH = 10,
  parameter IRQ_COUNT = 8
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_b,
  // decoded operation from the control unit
  input wire opValid,
  input wire [4:0] opCode,
  input wire [4:0] opDst,
  input wire [4:0] opSrc,
  input wire [7:0] opImm,
  input wire opUseImm,
  input wire [2:0] opBit,
  input wire [1:0] opPtrSel,
  input wire [5:0] opIoAddr,
  input wire opIoSpace,
  input wire opTwoWord,
  input wire [PC_WIDTH-1:0] opTarget,
  // program memory bus
  input wire [15:0] progData,
  output reg [PC_WIDTH-1:0] progAddr,
  output reg [15:0] fetchWord,
  output reg tableRead,
  output reg [15:0] tableAddr,
  // data memory bus
  output reg [15:0] dataAddr,
  output reg [7:0] dataWrData,
  output reg dataWrEn,
  output reg dataRdEn,
  input wire [7:0] dataRdData,
  // interrupt requests and state
  input wire [IRQ_COUNT-1:0] irqReq,
  output reg irqTaken,
  output reg [PC_WIDTH-1:0] irqVector,
  output reg [7:0] statusFlags,
  output reg [15:0] stackTop
);
  // ====================================================
  // state
  reg [7:0] flags_reg;
  reg [7:0] flags_next;
  reg [15:0] stack_reg;
  reg [15:0] stack_next;
  reg [PC_WIDTH-1:0] pc_reg;
  reg [PC_WIDTH-1:0] pc_next;
  wire [7:0] rdA;
  wire [7:0] rdB;
  wire [15:0] rdPair;
  wire [15:0] aluResult;
  wire [7:0] aluFlags;
  reg [4:0] rfRdA;
  reg wrLo;
  reg wrHi;
  reg [4:0] wrAddr;
  reg [15:0] wrData;
  reg [15:0] ptrAddr;
  reg [15:0] effAddr;
  reg irqPick;
  reg [PC_WIDTH-1:0] irqVec;
  integer i;

  // byte address of a pointer pair base; pairs start at register 26
  function [4:0] ptr_base;
    input [1:0] sel;
    begin
      case (sel)
        2'd0: ptr_base = `CRF_PTR_X; // RULE24
        2'd1: ptr_base = `CRF_PTR_Y;
        default: ptr_base = `CRF_PTR_Z;
      endcase
    end
  endfunction

  // true when a data address lands in the register file
  function is_reg_addr;
    input [15:0] a;
    begin
      is_reg_addr = (a < `CRF_REG_COUNT); // RULE19
    end
  endfunction

  // true when a data address lands in I/O space
  function is_io_addr;
    input [15:0] a;
    begin
      is_io_addr = (a >= `CRF_IO_FIRST) && (a <= `CRF_IO_LAST); // RULE11
    end
  endfunction

  // ====================================================
  // register file and ALU
  crf_reg_file #(
    .COUNT(`CRF_REG_COUNT)
  ) u_regs (
    .sys_clk(sys_clk),
    .rdAddrA(rfRdA),
    .rdAddrB(opSrc),
    .rdDataA(rdA),
    .rdDataB(rdB),
    .rdPair(rdPair),
    .wrEnLo(wrLo),
    .wrEnHi(wrHi),
    .wrAddr(wrAddr),
    .wrData(wrData)
  ); // RULE2 RULE18

  crf_alu u_alu (
    .op(opCode),
    .bitSel(opBit),
    .opA(rdA),
    .opB(opUseImm ? opImm : rdB),
    .opW(rdPair),
    .flagsIn(flags_reg),
    .result(aluResult),
    .flagsOut(aluFlags)
  ); // RULE6

  // ====================================================
  // interrupt pick: lowest index wins, only while the gate is open
  always @*
  begin
    irqPick = 1'b0;
    irqVec = {PC_WIDTH{1'b0}};
    for (i = IRQ_COUNT - 1; i >= 0; i = i - 1)
      if (irqReq[i])
      begin
        irqPick = flags_reg[`CRF_FLAG_I]; // RULE12
        irqVec = i[PC_WIDTH-1:0] + {{(PC_WIDTH-1){1'b0}}, 1'b1}; // RULE10
      end
    // a gate-clear op blocks even a simultaneous request
    if (opValid && opCode == `CRF_OP_FLAG_CLR && opBit == `CRF_FLAG_I)
      irqPick = 1'b0;
  end

  // ====================================================
  // pointer and effective data address; pointers may hit registers
  always @*
  begin
    rfRdA = opDst;
    if (opCode == `CRF_OP_LOAD || opCode == `CRF_OP_STORE)
      rfRdA = ptr_base(opPtrSel); // RULE4
    else if (opCode == `CRF_OP_TABLE_READ)
      rfRdA = `CRF_PTR_Z; // RULE5
    else if (opCode == `CRF_OP_MOVW)
      rfRdA = opSrc; // RULE18
    ptrAddr = rdPair;
    effAddr = opIoSpace ? ({10'h000, opIoAddr} + `CRF_IO_FIRST) : ptrAddr;
  end

  // ====================================================
  // writeback, flags, stack and pc next state
  always @*
  begin
    wrLo = 1'b0;
    wrHi = 1'b0;
    wrAddr = opDst;
    wrData = aluResult;
    flags_next = flags_reg;
    stack_next = stack_reg;
    pc_next = pc_reg + (opTwoWord ? 2'd2 : 2'd1); // RULE9
    if (irqPick)
    begin
      // entry: lower stack by two without writing the return, close gate, flags otherwise untouched
      stack_next = stack_reg - 16'h0002; // RULE21 RULE23
      flags_next[`CRF_FLAG_I] = 1'b0; // RULE13 RULE8
      pc_next = irqVec;
    end
    else if (opValid)
    begin
      case (opCode)
        `CRF_OP_CP, `CRF_OP_BIT_INTO_HOLDER, `CRF_OP_FLAG_SET,
        `CRF_OP_FLAG_CLR:
          flags_next = aluFlags; // RULE7
        `CRF_OP_MOVW, `CRF_OP_ADIW, `CRF_OP_SBIW:
        begin
          wrLo = 1'b1;
          wrHi = 1'b1; // RULE18
          flags_next = aluFlags;
        end
        `CRF_OP_LOAD, `CRF_OP_POP:
        begin
          wrLo = 1'b1;
          wrData = {8'h00, is_reg_addr(effAddr) ? rdB : dataRdData}; // RULE20
          if (opCode == `CRF_OP_POP)
            stack_next = stack_reg + 16'h0001; // RULE23
        end
        `CRF_OP_TABLE_READ:
        begin
          wrLo = 1'b1;
          wrData = {8'h00, progData[7:0]};
        end
        `CRF_OP_STORE:
        begin
          // store to register-mapped data address goes to the file
          wrLo = is_reg_addr(effAddr); // RULE20
          wrAddr = effAddr[4:0];
          wrData = {8'h00, rdB};
          // offset inside the window: data 0x20..0x5f maps to io 0..63
          if (is_io_addr(effAddr) &&
              {~effAddr[5], effAddr[4:0]} == `CRF_IO_STATUS)
            flags_next = rdB; // RULE11
        end
        `CRF_OP_PUSH: stack_next = stack_reg - 16'h0001; // RULE23
        `CRF_OP_CALL:
        begin
          stack_next = stack_reg - 16'h0002; // RULE21
          pc_next = opTarget;
        end
        `CRF_OP_TRAP_RETURN:
        begin
          stack_next = stack_reg + 16'h0002; // RULE23
          flags_next[`CRF_FLAG_I] = 1'b1; // RULE13
          pc_next = opTarget;
        end
        `CRF_OP_NOP: wrLo = 1'b0;
        default:
        begin
          wrLo = 1'b1; // RULE3
          flags_next = aluFlags; // RULE7
        end
      endcase
    end
  end

  // ====================================================
  // registered state and outputs; prefetch overlaps execution
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      flags_reg <= `CRF_FLAGS_RESET;
      stack_reg <= `CRF_STACK_RESET;
      pc_reg <= {PC_WIDTH{1'b0}};
      progAddr <= {PC_WIDTH{1'b0}};
      fetchWord <= 16'h0000;
      tableRead <= 1'b0;
      tableAddr <= 16'h0000;
      dataAddr <= 16'h0000;
      dataWrData <= 8'h00;
      dataWrEn <= 1'b0;
      dataRdEn <= 1'b0;
      irqTaken <= 1'b0;
      irqVector <= {PC_WIDTH{1'b0}};
      statusFlags <= `CRF_FLAGS_RESET;
      stackTop <= `CRF_STACK_RESET;
    end
    else
    begin
      flags_reg <= flags_next;
      stack_reg <= stack_next;
      pc_reg <= pc_next;
      progAddr <= pc_next; // RULE1
      fetchWord <= progData; // RULE1
      tableRead <= opValid && opCode == `CRF_OP_TABLE_READ;
      tableAddr <= (opValid && !irqPick && opCode == `CRF_OP_TABLE_READ) ?
        rdPair : tableAddr; // RULE5
      dataAddr <= (opCode == `CRF_OP_PUSH || opCode == `CRF_OP_CALL) ?
        stack_reg : effAddr;
      dataWrData <= rdB;
      dataWrEn <= opValid && !irqPick && (opCode == `CRF_OP_PUSH ||
        (opCode == `CRF_OP_STORE && !is_reg_addr(effAddr)));
      dataRdEn <= opValid && !irqPick && (opCode == `CRF_OP_POP ||
        (opCode == `CRF_OP_LOAD && !is_reg_addr(effAddr)));
      irqTaken <= irqPick;
      irqVector <= irqVec;
      statusFlags <= flags_next;
      stackTop <= stack_next;
    end
  end
endmodule
`default_nettype wire

/* design/crf_consts.vh */
// constants for the core execution datapath: status bits, spaces, ops
// assumes inclusion by the datapath and ALU modules, the monitor and the bench
`ifndef CRF_CONSTS_VH
`define CRF_CONSTS_VH
// ====================================================
// status flag bit positions
`define CRF_FLAG_C 0
`define CRF_FLAG_Z 1
`define CRF_FLAG_N 2
`define CRF_FLAG_V 3
`define CRF_FLAG_S 4
`define CRF_FLAG_H 5
`define CRF_FLAG_T 6
`define CRF_FLAG_I 7
`define CRF_FLAGS_RESET 8'h00
// ====================================================
// data space map
`define CRF_REG_COUNT 32
`define CRF_IO_FIRST 16'h0020
`define CRF_IO_LAST 16'h005f
`define CRF_IO_COUNT 64
`define CRF_IO_STATUS 6'h3f
`define CRF_IO_STACK_LO 6'h3d
`define CRF_IO_STACK_HI 6'h3e
`define CRF_PTR_X 5'h1a
`define CRF_PTR_Y 5'h1c
`define CRF_PTR_Z 5'h1e
`define CRF_STACK_RESET 16'h0000
// ====================================================
// operation codes
`define CRF_OP_NOP 5'h00
`define CRF_OP_ADD 5'h01
`define CRF_OP_ADC 5'h02
`define CRF_OP_SUB 5'h03
`define CRF_OP_SBC 5'h04
`define CRF_OP_AND 5'h05
`define CRF_OP_OR 5'h06
`define CRF_OP_XOR 5'h07
`define CRF_OP_COM 5'h08
`define CRF_OP_NEG 5'h09
`define CRF_OP_INC 5'h0a
`define CRF_OP_DEC 5'h0b
`define CRF_OP_LSR 5'h0c
`define CRF_OP_ROR 5'h0d
`define CRF_OP_ASR 5'h0e
`define CRF_OP_SWAP 5'h0f
`define CRF_OP_MOV 5'h10
`define CRF_OP_ADIW 5'h11
`define CRF_OP_SBIW 5'h12
`define CRF_OP_MOVW 5'h13
`define CRF_OP_BIT_INTO_HOLDER 5'h14
`define CRF_OP_BIT_FROM_HOLDER 5'h15
`define CRF_OP_FLAG_SET 5'h16
`define CRF_OP_FLAG_CLR 5'h17
`define CRF_OP_CP 5'h18
`define CRF_OP_LOAD 5'h19
`define CRF_OP_STORE 5'h1a
`define CRF_OP_TABLE_READ 5'h1b
`define CRF_OP_PUSH 5'h1c
`define CRF_OP_POP 5'h1d
`define CRF_OP_CALL 5'h1e
`define CRF_OP_TRAP_RETURN 5'h1f
`endif

/* design/crf_reg_file.v */
// 32 x 8 general register file with two 8-bit read ports and 16-bit write
// assumes the datapath presents addresses and data on the same clock
`timescale 1ns/1ps
`default_nettype none
module crf_reg_file #(
  parameter COUNT = 32
) (
  // clock only, no reset
  input wire sys_clk,
  // read ports, combinational so operate-and-write fits one cycle
  input wire [4:0] rdAddrA,
  input wire [4:0] rdAddrB,
  output wire [7:0] rdDataA,
  output wire [7:0] rdDataB,
  output wire [15:0] rdPair,
  // write port, low byte and optional high byte at the address with bit 0 set
  input wire wrEnLo,
  input wire wrEnHi,
  input wire [4:0] wrAddr,
  input wire [15:0] wrData
);
  // ====================================================
  // storage
  reg [7:0] regs [0:COUNT-1];
  wire [4:0] wrAddrHi;
  wire [4:0] rdAddrPair;
  assign wrAddrHi = wrAddr | 5'h01;
  assign rdAddrPair = rdAddrA | 5'h01;
  // asynchronous read keeps the whole ALU step in one clock
  assign rdDataA = regs[rdAddrA];
  assign rdDataB = regs[rdAddrB];
  assign rdPair = {regs[rdAddrPair], regs[rdAddrA]};
  // writes; registers are not reset, as in SRAM-like storage
  always @(posedge sys_clk)
  begin
    if (wrEnLo)
      regs[wrAddr] <= wrData[7:0];
    if (wrEnHi)
      regs[wrAddrHi] <= wrData[15:8];
  end
endmodule
`default_nettype wire

/* design/crf_alu.v */
// single-cycle ALU producing result and the full next flag byte
// assumes flagsIn is the current status byte
`timescale 1ns/1ps
`default_nettype none
`include "crf_consts.vh"
module crf_alu (
  // operation select
  input wire [4:0] op,
  input wire [2:0] bitSel,
  // operands
  input wire [7:0] opA,
  input wire [7:0] opB,
  input wire [15:0] opW,
  input wire [7:0] flagsIn,
  // results
  output reg [15:0] result,
  output reg [7:0] flagsOut
);
  reg [8:0] sum;
  reg [16:0] wsum;
  reg cIn;
  // ====================================================
  // compute; flags not defined by an op keep their value
  always @*
  begin
    sum = 9'h000;
    wsum = 17'h00000;
    cIn = flagsIn[`CRF_FLAG_C];
    result = {8'h00, opA};
    flagsOut = flagsIn; // RULE25
    case (op)
      `CRF_OP_ADD, `CRF_OP_ADC:
      begin
        sum = {1'b0, opA} + {1'b0, opB} +
          {8'h00, (op == `CRF_OP_ADC) & cIn};
        result = {8'h00, sum[7:0]};
        flagsOut[`CRF_FLAG_C] = sum[8];
        flagsOut[`CRF_FLAG_H] = (opA[3] & opB[3]) | (opB[3] & ~sum[3]) |
          (~sum[3] & opA[3]); // RULE15
        flagsOut[`CRF_FLAG_V] = (opA[7] & opB[7] & ~sum[7]) |
          (~opA[7] & ~opB[7] & sum[7]);
      end
      `CRF_OP_SUB, `CRF_OP_SBC, `CRF_OP_CP, `CRF_OP_NEG:
      begin
        if (op == `CRF_OP_NEG)
          sum = 9'h000 - {1'b0, opA};
        else
          sum = {1'b0, opA} - {1'b0, opB} -
            {8'h00, (op == `CRF_OP_SBC) & cIn};
        if (op != `CRF_OP_CP)
          result = {8'h00, sum[7:0]};
        flagsOut[`CRF_FLAG_C] = sum[8];
        flagsOut[`CRF_FLAG_H] = (op == `CRF_OP_NEG) ? (sum[3] | opA[3]) :
          ((~opA[3] & opB[3]) | (opB[3] & sum[3]) | (sum[3] & ~opA[3]));
        flagsOut[`CRF_FLAG_V] = (op == `CRF_OP_NEG) ? (sum[7:0] == 8'h80) :
          ((opA[7] & ~opB[7] & ~sum[7]) | (~opA[7] & opB[7] & sum[7]));
      end
      `CRF_OP_AND, `CRF_OP_OR, `CRF_OP_XOR, `CRF_OP_COM:
      begin
        case (op)
          `CRF_OP_AND: result = {8'h00, opA & opB};
          `CRF_OP_OR: result = {8'h00, opA | opB};
          `CRF_OP_XOR: result = {8'h00, opA ^ opB};
          default: result = {8'h00, ~opA};
        endcase
        flagsOut[`CRF_FLAG_V] = 1'b0;
        if (op == `CRF_OP_COM)
          flagsOut[`CRF_FLAG_C] = 1'b1;
      end
      `CRF_OP_INC, `CRF_OP_DEC:
      begin
        result = {8'h00, (op == `CRF_OP_INC) ? opA + 8'h01 : opA - 8'h01};
        flagsOut[`CRF_FLAG_V] = (op == `CRF_OP_INC) ? (opA == 8'h7f) :
          (opA == 8'h80);
      end
      `CRF_OP_LSR, `CRF_OP_ROR, `CRF_OP_ASR:
      begin
        case (op)
          `CRF_OP_LSR: result = {8'h00, 1'b0, opA[7:1]};
          `CRF_OP_ROR: result = {8'h00, cIn, opA[7:1]};
          default: result = {8'h00, opA[7], opA[7:1]};
        endcase
        flagsOut[`CRF_FLAG_C] = opA[0];
        flagsOut[`CRF_FLAG_V] = result[7] ^ opA[0];
      end
      `CRF_OP_SWAP: result = {8'h00, opA[3:0], opA[7:4]};
      `CRF_OP_MOV: result = {8'h00, opB};
      `CRF_OP_MOVW: result = opW;
      `CRF_OP_ADIW, `CRF_OP_SBIW:
      begin
        if (op == `CRF_OP_ADIW)
          wsum = {1'b0, opW} + {11'h000, opB[5:0]};
        else
          wsum = {1'b0, opW} - {11'h000, opB[5:0]};
        result = wsum[15:0];
        flagsOut[`CRF_FLAG_C] = wsum[16];
        flagsOut[`CRF_FLAG_V] = (op == `CRF_OP_ADIW) ?
          (~opW[15] & wsum[15]) : (opW[15] & ~wsum[15]);
      end
      `CRF_OP_BIT_INTO_HOLDER:
        flagsOut[`CRF_FLAG_T] = opA[bitSel]; // RULE14
      `CRF_OP_BIT_FROM_HOLDER:
      begin
        result = {8'h00, opA};
        result[bitSel] = flagsIn[`CRF_FLAG_T]; // RULE14
      end
      `CRF_OP_FLAG_SET: flagsOut[bitSel] = 1'b1;
      `CRF_OP_FLAG_CLR: flagsOut[bitSel] = 1'b0;
      default: result = {8'h00, opA};
    endcase
    // N, Z, S for ops that define them
    case (op)
      `CRF_OP_NOP, `CRF_OP_MOV, `CRF_OP_MOVW, `CRF_OP_SWAP,
      `CRF_OP_BIT_INTO_HOLDER, `CRF_OP_BIT_FROM_HOLDER,
      `CRF_OP_FLAG_SET, `CRF_OP_FLAG_CLR, `CRF_OP_LOAD, `CRF_OP_STORE,
      `CRF_OP_TABLE_READ, `CRF_OP_PUSH, `CRF_OP_POP, `CRF_OP_CALL,
      `CRF_OP_TRAP_RETURN:
        flagsOut = flagsOut;
      `CRF_OP_ADIW, `CRF_OP_SBIW:
      begin
        flagsOut[`CRF_FLAG_N] = result[15];
        flagsOut[`CRF_FLAG_Z] = (result == 16'h0000);
        flagsOut[`CRF_FLAG_S] = result[15] ^ flagsOut[`CRF_FLAG_V];
      end
      default:
      begin
        flagsOut[`CRF_FLAG_N] = result[7]; // RULE17
        flagsOut[`CRF_FLAG_Z] = (result[7:0] == 8'h00);
        flagsOut[`CRF_FLAG_S] = result[7] ^ flagsOut[`CRF_FLAG_V]; // RULE16
      end
    endcase
  end
endmodule
`default_nettype wire

/* sim/crf_core_datapath_monitor.sv */
// checker for the core datapath: flag, gate, stack and data map relations
// sees only top-level ports; bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
`include "crf_consts.vh"
module crf_core_datapath_monitor #(
  parameter PC_WIDTH = 10,
  parameter IRQ_COUNT = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // decoded operation
  input wire logic opValid,
  input wire logic [4:0] opCode,
  input wire logic [2:0] opBit,
  input wire logic [5:0] opIoAddr,
  input wire logic opIoSpace,
  // data bus, interrupts and state
  input wire logic [15:0] dataAddr,
  input wire logic dataWrEn,
  input wire logic [IRQ_COUNT-1:0] irqReq,
  input wire logic irqTaken,
  input wire logic [PC_WIDTH-1:0] irqVector,
  input wire logic [7:0] statusFlags,
  input wire logic [15:0] stackTop
);
  // ==========================================================
  // helpers: requests seen at the deciding edge, lower ones only
  logic [IRQ_COUNT-1:0] reqSeen_reg;
  wire gateOpen = statusFlags[7];
  // shifting drops the winner and above, so any bit left is a better request
  wire [IRQ_COUNT-1:0] lowerReq = reqSeen_reg << (IRQ_COUNT + 1 - irqVector);
  always @(posedge sys_clk)
  begin
    reqSeen_reg <= irqReq;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // ==========================================================
  // flag, interrupt gate, stack and io window relations
  sign_relation_a: assert property (statusFlags[4] == (statusFlags[2] ^ statusFlags[3]))
    else $error("sign flag differs from negative xor overflow");
  gate_blocks_irq_a: assert property (!gateOpen |=> !irqTaken)
    else $error("interrupt taken while gate closed");
  irq_gate_clear_a: assert property (irqTaken |-> !gateOpen)
    else $error("gate still open after interrupt entry");
  irq_flags_kept_a: assert property (irqTaken |-> statusFlags[6:0] == $past(statusFlags[6:0]))
    else $error("flags altered by interrupt entry");
  irq_stack_step_a: assert property (irqTaken |-> stackTop == $past(stackTop) - 16'h0002)
    else $error("stack not lowered by two on interrupt");
  irq_priority_a: assert property (irqTaken |-> irqVector != 0 && reqSeen_reg[irqVector - 1] && lowerReq == 0)
    else $error("interrupt winner is not the lowest pending request");
  gate_clear_op_a: assert property (opValid && opCode == `CRF_OP_FLAG_CLR && opBit == 3'h7 |=> !irqTaken && !gateOpen)
    else $error("gate clear did not block interrupts at once");
  ret_restore_a: assert property (opValid && opCode == `CRF_OP_TRAP_RETURN && !gateOpen |=> $rose(gateOpen) && stackTop == $past(stackTop) + 16'h0002)
    else $error("return did not open gate and raise stack by two");
  push_step_a: assert property (opValid && opCode == `CRF_OP_PUSH && !gateOpen |=> dataWrEn && stackTop == $past(stackTop) - 16'h0001)
    else $error("push did not write and lower stack by one");
  io_window_a: assert property (opValid && opCode == `CRF_OP_STORE && opIoSpace && opIoAddr < 6'h3d && !gateOpen |=> dataWrEn && dataAddr == 16'h0020 + $past(opIoAddr))
    else $error("io store not placed at data address 0x20 plus offset");

  // main scenarios reached
  irq_seen_c: cover property (irqTaken);
  push_seen_c: cover property (opValid && opCode == `CRF_OP_PUSH);
  ret_seen_c: cover property (opValid && opCode == `CRF_OP_TRAP_RETURN);
endmodule
`default_nettype wire

/* sim/crf_core_datapath_tb.sv */
// self-checking bench for the core execution datapath
// the bench plays decoder and memories; ops go in at the falling edge
`timescale 1ns/1ps
`default_nettype none
`include "crf_consts.vh"
module crf_core_datapath_tb;
  // ==========================================================
  // signals
  localparam PCW = 10;
  localparam NIRQ = 8;
  logic sys_clk, rst_b, opValid, opUseImm, opIoSpace, opTwoWord;
  logic tableRead, dataWrEn, dataRdEn, irqTaken;
  logic [4:0] opCode, opDst, opSrc;
  logic [7:0] opImm, dataRdData, dataWrData, statusFlags, f;
  logic [2:0] opBit;
  logic [1:0] opPtrSel;
  logic [5:0] opIoAddr;
  logic [PCW-1:0] opTarget, progAddr, irqVector, pc;
  logic [15:0] progData, fetchWord, tableAddr, dataAddr, stackTop, sp;
  logic [NIRQ-1:0] irqReq;
  logic [7:0] va [4] = '{8'h7f, 8'hff, 8'h08, 8'h00};
  logic [7:0] vb [4] = '{8'h01, 8'h01, 8'h08, 8'h01};
  int n_errors = 0;
  int num_checks = 0;
  int i, j;

  crf_core_datapath #(.PC_WIDTH(PCW), .IRQ_COUNT(NIRQ)) crf_core_datapath_inst (
    .sys_clk, .rst_b, .opValid, .opCode, .opDst, .opSrc, .opImm, .opUseImm,
    .opBit, .opPtrSel, .opIoAddr, .opIoSpace, .opTwoWord, .opTarget,
    .progData, .progAddr, .fetchWord, .tableRead, .tableAddr, .dataAddr,
    .dataWrData, .dataWrEn, .dataRdEn, .dataRdData, .irqReq, .irqTaken,
    .irqVector, .statusFlags, .stackTop
  );

  // 10 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // access tasks
  // case inequality so an unknown never passes
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // present one op for the next rising edge
  task op(input logic [4:0] c, d, s, input logic [7:0] k, input logic u,
    input logic [2:0] b);
    @(negedge sys_clk);
    opValid = 1'b1;
    opCode = c;
    opDst = d;
    opSrc = s;
    opImm = k;
    opUseImm = u;
    opBit = b;
  endtask

  // drop the op and clear side fields
  task idle;
    @(negedge sys_clk);
    opValid = 1'b0;
    opIoSpace = 1'b0;
    opTwoWord = 1'b0;
  endtask

  task ldi(input logic [4:0] r, input logic [7:0] k);
    op(`CRF_OP_MOV, r, 5'h00, k, 1'b1, 3'h0);
  endtask

  // read a pair back through the table pointer (clobbers r0 and Z)
  task peek(input logic [4:0] r, input logic [15:0] e);
    op(`CRF_OP_MOVW, 5'h1e, r, 8'h00, 1'b0, 3'h0);
    op(`CRF_OP_TABLE_READ, 5'h00, 5'h00, 8'h00, 1'b0, 3'h0);
    idle;
    chk(tableAddr, e);
    chk({15'h0000, tableRead}, 16'h0001);
  endtask

  // expected flags of an 8-bit add or subtract; gate and holder kept
  function automatic logic [7:0] arith(input logic [7:0] a, b, p,
    input logic sub);
    logic [8:0] r;
    logic h, v;
    r = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    h = sub ? a[3:0] < b[3:0] : {1'b0, a[3:0]} + {1'b0, b[3:0]} > 5'h0f;
    v = (sub ? a[7] != b[7] : a[7] == b[7]) && r[7] != a[7];
    return {p[7:6], h, r[7] ^ v, v, r[7], r[7:0] == 8'h00, r[8]};
  endfunction

  task results;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    rst_b = 1'b0;
    {opValid, opUseImm, opIoSpace, opTwoWord} = 4'h0;
    {opCode, opDst, opSrc, opBit, opPtrSel} = 20'h00000;
    {opImm, opIoAddr, opTarget} = 24'h000000;
    {progData, dataRdData, irqReq} = 32'h5a3c0000;
    repeat (5) @(negedge sys_clk);
    rst_b = 1'b1;
    chk({8'h00, statusFlags}, 16'h0000);
    chk(stackTop, 16'h0000);
    // back-to-back loads feed the alu op the very next cycle
    ldi(5'h03, 8'h00);
    for (i = 0; i < 4; i++)
      for (j = 0; j < 3; j++)
      begin
        f = arith(va[i], vb[i], statusFlags, j == 1);
        ldi(5'h02, va[i]);
        ldi(5'h04, vb[i]);
        op(j == 1 ? `CRF_OP_SUB : `CRF_OP_ADD, 5'h02, 5'h04, vb[i], j == 2,
          3'h0);
        idle;
        chk({8'h00, statusFlags}, {8'h00, f});
        peek(5'h02, {8'h00, j == 1 ? va[i] - vb[i] : va[i] + vb[i]});
      end
    // single operand op leaves half carry alone
    f = statusFlags;
    ldi(5'h02, 8'h0f);
    op(`CRF_OP_COM, 5'h02, 5'h00, 8'h00, 1'b0, 3'h0);
    idle;
    chk({8'h00, statusFlags}, {8'h00, f[7:5], 5'h15});
    peek(5'h02, 16'h00f0);
    ldi(5'h18, 8'hff);
    ldi(5'h19, 8'h00);
    op(`CRF_OP_ADIW, 5'h18, 5'h00, 8'h01, 1'b1, 3'h0);
    peek(5'h18, 16'h0100);
    $display("test alu done");
    // bit holder both ways
    ldi(5'h06, 8'h20);
    ldi(5'h08, 8'h00);
    ldi(5'h09, 8'h00);
    op(`CRF_OP_BIT_INTO_HOLDER, 5'h06, 5'h00, 8'h00, 1'b0, 3'h5);
    op(`CRF_OP_BIT_FROM_HOLDER, 5'h08, 5'h00, 8'h00, 1'b0, 3'h1);
    idle;
    chk({15'h0000, statusFlags[6]}, 16'h0001);
    peek(5'h08, 16'h0002);
    op(`CRF_OP_BIT_INTO_HOLDER, 5'h06, 5'h00, 8'h00, 1'b0, 3'h0);
    idle;
    chk({15'h0000, statusFlags[6]}, 16'h0000);
    $display("test holder done");
    // pointer store, register reached through a pointer, io window at offsets 0x00 and 0x3c
    ldi(5'h1a, 8'h34);
    ldi(5'h1b, 8'h12);
    ldi(5'h1c, 8'h04);
    ldi(5'h1d, 8'h00);
    ldi(5'h04, 8'hc5);
    ldi(5'h0d, 8'h00);
    op(`CRF_OP_STORE, 5'h00, 5'h02, 8'h00, 1'b0, 3'h0);
    opPtrSel = 2'h0;
    idle;
    chk(dataAddr, 16'h1234);
    chk({15'h0000, dataWrEn}, 16'h0001);
    chk({8'h00, dataWrData}, 16'h00f0);
    op(`CRF_OP_LOAD, 5'h0c, 5'h04, 8'h00, 1'b0, 3'h0);
    opPtrSel = 2'h1;
    peek(5'h0c, 16'h00c5);
    for (i = 0; i < 2; i++)
    begin
      op(`CRF_OP_STORE, 5'h00, 5'h02, 8'h00, 1'b0, 3'h0);
      opIoSpace = 1'b1;
      opIoAddr = i ? 6'h3c : 6'h00;
      idle;
      chk(dataAddr, 16'h0020 + (i ? 16'h003c : 16'h0000));
    end
    // one-word then two-word op advance the fetch address by three
    op(`CRF_OP_NOP, 5'h00, 5'h00, 8'h00, 1'b0, 3'h0);
    pc = progAddr;
    op(`CRF_OP_NOP, 5'h00, 5'h00, 8'h00, 1'b0, 3'h0);
    opTwoWord = 1'b1;
    idle;
    chk({6'h00, progAddr}, {6'h00, pc + 10'h003});
    chk(fetchWord, 16'h5a3c);
    $display("test data space done");
    // stack moves by one per byte and two per return address
    sp = stackTop;
    op(`CRF_OP_PUSH, 5'h02, 5'h02, 8'h00, 1'b0, 3'h0);
    idle;
    chk(stackTop, sp - 16'h0001);
    op(`CRF_OP_POP, 5'h0a, 5'h00, 8'h00, 1'b0, 3'h0);
    idle;
    chk(stackTop, sp);
    chk({15'h0000, dataRdEn}, 16'h0001);
    op(`CRF_OP_CALL, 5'h00, 5'h00, 8'h00, 1'b0, 3'h0);
    opTarget = 10'h155;
    idle;
    chk(stackTop, sp - 16'h0002);
    f = statusFlags;
    op(`CRF_OP_TRAP_RETURN, 5'h00, 5'h00, 8'h00, 1'b0, 3'h0);
    idle;
    chk(stackTop, sp);
    chk({8'h00, statusFlags}, {8'h00, f | 8'h80});
    $display("test stack done");
    // two requests pending: the lower index wins
    sp = stackTop;
    f = statusFlags;
    irqReq = 8'h24;
    for (i = 0; i < 8 && irqTaken !== 1'b1; i++)
      @(negedge sys_clk);
    chk({15'h0000, irqTaken}, 16'h0001);
    if (irqTaken !== 1'b1)
      results;
    chk({6'h00, irqVector}, 16'h0003);
    chk({8'h00, statusFlags}, {8'h00, f & 8'h7f});
    chk(stackTop, sp - 16'h0002);
    // gate closed by entry, then a clear racing a pending request
    repeat (3)
    begin
      @(negedge sys_clk);
      chk({15'h0000, irqTaken}, 16'h0000);
    end
    op(`CRF_OP_FLAG_SET, 5'h00, 5'h00, 8'h00, 1'b0, 3'h7);
    op(`CRF_OP_FLAG_CLR, 5'h00, 5'h00, 8'h00, 1'b0, 3'h7);
    repeat (3)
    begin
      idle;
      chk({15'h0000, irqTaken}, 16'h0000);
    end
    chk({15'h0000, statusFlags[7]}, 16'h0000);
    irqReq = 8'h00;
    $display("test interrupt done");
    results;
  end
endmodule

bind crf_core_datapath crf_core_datapath_monitor #(
  .PC_WIDTH(PC_WIDTH),
  .IRQ_COUNT(IRQ_COUNT)
) crf_core_datapath_monitor_inst (
  .sys_clk, .rst_b, .opValid, .opCode, .opBit, .opIoAddr, .opIoSpace,
  .dataAddr, .dataWrEn, .irqReq, .irqTaken, .irqVector, .statusFlags,
  .stackTop
);
`default_nettype wire
